// ---- hw/sdcrb_device.sv ----
`timescale 1ns/1ns
`include "sdcrb_params.svh"
module sdcrb_device (
  input  wire logic        sys_clk_in,      // synchronisation clock
  input  wire logic        reset_n_in,      // async reset, active low
  sdcrb_link_if.device     link,            // register and parallel port
  output logic [31:0]      ftw_out,         // active frequency word
  output logic [15:0]      pow_out,         // active phase word
  output logic [11:0]      amp_out,         // active amplitude word
  output logic             sine_select_out, // 1 sine, 0 cosine
  output logic             stream_mode_out, // streaming active
  output logic             pll_cal_busy_out,// calibration running
  output logic             pll_locked_out   // pll lock indicator
);

  // =====================================================
  // state
  typedef struct packed {
    logic [31:0]             ctrl_buf;
    logic [31:0]             ctrl_act;
    logic [31:0]             p7_buf;
    logic [31:0]             p7_act;
    logic [23:0]             user_buf;
    logic [31:0]             ftw_pend;
    logic [15:0]             pow_pend;
    logic [11:0]             amp_pend;
    logic [31:0]             ftw_act;
    logic [15:0]             pow_act;
    logic [11:0]             amp_act;
    logic [2:0]              prof_q;
    logic                    cal_armed;
    logic                    cal_busy;
    logic [`SDCRB_CNT_W-1:0] cal_cnt;
    logic                    locked;
    logic [31:0]             rdata;
    logic                    rvalid;
    logic [15:0]             pow_o;
    logic [11:0]             amp_o;
  } sdcrb_dev_s;

  sdcrb_dev_s r;
  sdcrb_dev_s next_r;
  logic       xfer;

  // =====================================================
  // helpers
  // defaults after power-up or master reset
  function automatic sdcrb_dev_s sdcrb_defaults();
    sdcrb_dev_s d;
    d           = '0;
    d.ctrl_buf  = `SDCRB_CTRL_ONE_RESET;
    d.ctrl_act  = `SDCRB_CTRL_ONE_RESET;
    d.p7_buf    = `SDCRB_PROFILE7_RESET;
    d.p7_act    = `SDCRB_PROFILE7_RESET;
    d.user_buf  = 24'(`SDCRB_USER_CFG_RESET);
    d.cal_armed = 1'b1;
    return d;
  endfunction : sdcrb_defaults

  // byte-lane merge, only writable bits take the new value
  function automatic logic [31:0] sdcrb_merge(input logic [31:0] old_val,
                                              input logic [31:0] new_val,
                                              input logic [3:0]  be,
                                              input logic [31:0] wmask);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{be[i]}};
    end
    m = m & wmask;
    return (old_val & ~m) | (new_val & m);
  endfunction : sdcrb_merge

  // register read decode; bit numbering follows lsb = bit 0
  function automatic logic [31:0] sdcrb_read(input sdcrb_dev_s s,
                                             input logic [`SDCRB_ADDR_W-1:0] a);
    logic [31:0] v;
    v = '0;
    case (a)
      `SDCRB_OFF_CTRL_ONE: v = s.ctrl_buf & `SDCRB_CTRL_ONE_WMASK;
      `SDCRB_OFF_PROFILE7: v = s.p7_buf & `SDCRB_PROFILE7_WMASK;
      `SDCRB_OFF_USER_CFG: begin
        v = {8'h00, s.user_buf};
        v[`SDCRB_LOCK_BIT] = s.locked;
      end
      default: v = '0;
    endcase
    return v;
  endfunction : sdcrb_read

  // =====================================================
  // next state
  always_comb begin
    next_r = r;
    xfer   = link.io_update || (link.profile_sel != r.prof_q);

    // reads answer one cycle later even during master reset
    next_r.rvalid = link.rd_en;
    if (link.rd_en) begin
      next_r.rdata = sdcrb_read(r, link.addr);
    end

    if (link.master_reset) begin
      next_r        = sdcrb_defaults();
      next_r.rvalid = link.rd_en;
      // a read taken here still carries the register contents, not stale data
      next_r.rdata  = link.rd_en ? sdcrb_read(r, link.addr) : r.rdata;
      next_r.prof_q = link.profile_sel;
    end else begin
      next_r.prof_q = link.profile_sel;

      // register writes land in the buffer copies only
      if (link.wr_en && (link.addr <= `SDCRB_LAST_ADDR)) begin
        case (link.addr)
          `SDCRB_OFF_CTRL_ONE: begin
            next_r.ctrl_buf = sdcrb_merge(r.ctrl_buf, link.wdata, link.be,
                                          `SDCRB_CTRL_ONE_WMASK);
          end
          `SDCRB_OFF_PROFILE7: begin
            next_r.p7_buf = sdcrb_merge(r.p7_buf, link.wdata, link.be,
                                        `SDCRB_PROFILE7_WMASK);
          end
          `SDCRB_OFF_USER_CFG: begin
            // lock bit sits outside the mask so writes cannot touch it
            next_r.user_buf = 24'(sdcrb_merge({8'h00, r.user_buf}, link.wdata,
                                              link.be, `SDCRB_USER_CFG_WMASK));
          end
          default: begin
          end
        endcase
      end

      // pll calibration: trigger acts at once, rearms only once cleared
      if (!r.ctrl_buf[`SDCRB_CAL_BIT]) begin
        next_r.cal_armed = 1'b1;
      end
      if (r.cal_busy) begin
        if (r.cal_cnt == `SDCRB_CNT_W'(1)) begin
          next_r.cal_busy = 1'b0;
          next_r.locked   = 1'b1;
        end else begin
          next_r.cal_cnt = r.cal_cnt - 1'b1;
        end
      end else if (r.ctrl_buf[`SDCRB_CAL_BIT] && r.cal_armed) begin
        next_r.cal_armed = 1'b0;
        next_r.cal_busy  = 1'b1;
        next_r.locked    = 1'b0;
        next_r.cal_cnt   = `SDCRB_CNT_W'(`SDCRB_PLL_CAL_CYC);
      end

      // parallel port: route by function pins
      if (r.ctrl_act[`SDCRB_STREAM_BIT]) begin
        case (link.func_sel)
          `SDCRB_FSEL_FTW: next_r.ftw_act = link.par_data;
          `SDCRB_FSEL_POW: next_r.pow_act = link.par_data[15:0];
          `SDCRB_FSEL_AMP: next_r.amp_act = link.par_data[11:0];
          default: begin
          end
        endcase
      end else begin
        // held back until the next transfer event
        case (link.func_sel)
          `SDCRB_FSEL_FTW: next_r.ftw_pend = link.par_data;
          `SDCRB_FSEL_POW: next_r.pow_pend = link.par_data[15:0];
          `SDCRB_FSEL_AMP: next_r.amp_pend = link.par_data[11:0];
          default: begin
          end
        endcase
      end

      // transfer buffered values into the core; same-cycle writes included
      if (xfer) begin
        next_r.ctrl_act = next_r.ctrl_buf;
        next_r.p7_act   = next_r.p7_buf;
        if (!r.ctrl_act[`SDCRB_STREAM_BIT]) begin
          next_r.ftw_act = next_r.ftw_pend;
          next_r.pow_act = next_r.pow_pend;
          next_r.amp_act = next_r.amp_pend;
        end
      end
    end

    // profile seven overrides phase and amplitude while selected
    if (next_r.prof_q == `SDCRB_PROFILE_SEVEN) begin
      next_r.pow_o = next_r.p7_act[`SDCRB_POW_LSB +: 16];
      next_r.amp_o = next_r.p7_act[`SDCRB_AMP_LSB +: 12];
    end else begin
      next_r.pow_o = next_r.pow_act;
      next_r.amp_o = next_r.amp_act;
    end
  end

  // =====================================================
  // state register
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      r <= sdcrb_defaults();
    end else begin
      r <= next_r;
    end
  end

  // =====================================================
  // outputs, all straight from the state register
  assign link.rdata       = r.rdata;
  assign link.rvalid      = r.rvalid;
  assign ftw_out          = r.ftw_act;
  assign pow_out          = r.pow_o;
  assign amp_out          = r.amp_o;
  assign sine_select_out  = r.ctrl_act[`SDCRB_SINE_BIT];
  assign stream_mode_out  = r.ctrl_act[`SDCRB_STREAM_BIT];
  assign pll_cal_busy_out = r.cal_busy;
  assign pll_locked_out   = r.locked;

endmodule : sdcrb_device

// ---- hw/sdcrb_params.svh ----
`ifndef SDCRB_PARAMS_SVH
`define SDCRB_PARAMS_SVH
// What this block does
// - decode word addresses 0x00..0x1b, 112 bytes
// - bit 0 is lsb, a:b inclusive
// - writes buffered, applied on update/profile change; calibration trigger acts from the buffer
// - profile seven phase word in low bytes
// - profile seven amplitude twelve bits, nibble unused
// - host keeps user bytes at 00 08 00
// - master reset restores every register default
// - host pulses dac calibration after clock change
// - writing calibration trigger starts pll calibration
// - trigger must return to zero first
// - streaming off: parallel data waits for update
// - streaming on: sample every edge, route by function
// - host meets setup/hold around clock edge
// - host changes function pins on clock edge
// - sine select zero gives cosine output
// - sine select one gives sine, reset state

// =====================================================
// widths and address map
`define SDCRB_ADDR_W        5
`define SDCRB_DATA_W        32
`define SDCRB_BE_W          4
`define SDCRB_NUM_WORDS     28
`define SDCRB_NUM_BYTES     112
`define SDCRB_LAST_ADDR     5'h1b
`define SDCRB_OFF_CTRL_ONE  5'h00
`define SDCRB_OFF_PROFILE7  5'h1a
`define SDCRB_OFF_USER_CFG  5'h1b

// =====================================================
// field positions
`define SDCRB_CAL_BIT       24
`define SDCRB_STREAM_BIT    17
`define SDCRB_SINE_BIT      16
`define SDCRB_LOCK_BIT      24
`define SDCRB_POW_LSB       0
`define SDCRB_AMP_LSB       16

// =====================================================
// writable masks and reset values
`define SDCRB_CTRL_ONE_WMASK 32'h0103_0000
`define SDCRB_CTRL_ONE_RESET 32'h0001_0000
`define SDCRB_PROFILE7_WMASK 32'h0fff_ffff
`define SDCRB_PROFILE7_RESET 32'h0000_0000
`define SDCRB_USER_CFG_WMASK 32'h00ff_ffff
`define SDCRB_USER_CFG_RESET 32'h0000_0800

// =====================================================
// function select codes on the parallel port, and the profile seven select code
`define SDCRB_FSEL_FTW      4'h0
`define SDCRB_FSEL_POW      4'h1
`define SDCRB_FSEL_AMP      4'h2
`define SDCRB_PROFILE_SEVEN 3'h7

// =====================================================
// timing
`define SDCRB_CLK_PERIOD_NS 8
`define SDCRB_PLL_CAL_NS    2000
`define SDCRB_PLL_CAL_CYC   ((`SDCRB_PLL_CAL_NS + `SDCRB_CLK_PERIOD_NS - 1) / `SDCRB_CLK_PERIOD_NS)
`define SDCRB_CNT_W         12
`define SDCRB_FIFO_DEPTH    16
`endif

// ---- hw/sdcrb_pkg.sv ----
`include "sdcrb_params.svh"
package sdcrb_pkg;

  // =====================================================
  // one register access as carried through the host fifo
  typedef struct packed {
    logic                       write;
    logic [`SDCRB_ADDR_W-1:0]   addr;
    logic [`SDCRB_BE_W-1:0]     be;
    logic [`SDCRB_DATA_W-1:0]   data;
  } sdcrb_cmd_s;

  typedef logic [$bits(sdcrb_cmd_s)-1:0] sdcrb_cmd_t;

  typedef enum logic [0:0] {
    SDCRB_HOST_IDLE,
    SDCRB_HOST_WAIT_RD
  } sdcrb_host_state_e;

endpackage : sdcrb_pkg

// ---- hw/sdcrb_link_if.sv ----
`timescale 1ns/1ns
`include "sdcrb_params.svh"
interface sdcrb_link_if;
  logic                     master_reset; // defaults restore request
  logic                     wr_en;        // register write strobe
  logic                     rd_en;        // register read strobe
  logic [`SDCRB_ADDR_W-1:0] addr;         // word address
  logic [`SDCRB_BE_W-1:0]   be;           // byte enables
  logic [`SDCRB_DATA_W-1:0] wdata;        // write data
  logic [`SDCRB_DATA_W-1:0] rdata;        // read data
  logic                     rvalid;       // read data valid
  logic                     io_update;    // transfer strobe
  logic [2:0]               profile_sel;  // profile select pins
  logic [3:0]               func_sel;     // function select pins
  logic [`SDCRB_DATA_W-1:0] par_data;     // parallel data port

  modport host (output master_reset, wr_en, rd_en, addr, be, wdata, io_update,
                output profile_sel, func_sel, par_data, input rdata, rvalid);
  modport device (input master_reset, wr_en, rd_en, addr, be, wdata, io_update,
                  input profile_sel, func_sel, par_data, output rdata, rvalid);
endinterface : sdcrb_link_if

// ---- hw/sdcrb_fifo.sv ----
`timescale 1ns/1ns
module sdcrb_fifo #(
  parameter int WIDTH = 42,
  parameter int DEPTH = 16
) (
  input  wire logic             sys_clk_in,   // system clock
  input  wire logic             reset_n_in,   // async reset, active low
  input  wire logic             in_valid_in,  // push request
  output logic                  in_ready_out, // room available
  input  wire logic [WIDTH-1:0] in_data_in,   // push data
  output logic                  out_valid_out,// word available
  input  wire logic             out_ready_in, // pop request
  output logic [WIDTH-1:0]      out_data_out  // head word
);
  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wr_ptr;
    logic [PW-1:0]               rd_ptr;
    logic [PW:0]                 count;
  } sdcrb_fifo_s;

  sdcrb_fifo_s r;
  sdcrb_fifo_s next_r;
  logic        push;
  logic        pop;

  // =====================================================
  // pointer and storage update
  always_comb begin
    next_r = r;
    push   = in_valid_in && (r.count != (PW+1)'(DEPTH));
    pop    = out_ready_in && (r.count != '0);
    if (push) begin
      next_r.mem[r.wr_ptr] = in_data_in;
      next_r.wr_ptr        = r.wr_ptr + 1'b1;
    end
    if (pop) begin
      next_r.rd_ptr = r.rd_ptr + 1'b1;
    end
    // simultaneous push and pop leaves the count alone
    if (push && !pop) begin
      next_r.count = r.count + 1'b1;
    end else if (pop && !push) begin
      next_r.count = r.count - 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // flags decode straight from the registered count
  assign in_ready_out  = (r.count != (PW+1)'(DEPTH));
  assign out_valid_out = (r.count != '0);
  assign out_data_out  = r.mem[r.rd_ptr];

endmodule : sdcrb_fifo

// ---- hw/sdcrb_host.sv ----
`timescale 1ns/1ns
`include "sdcrb_params.svh"
module sdcrb_host (
  input  wire logic        sys_clk_in,      // synchronisation clock
  input  wire logic        reset_n_in,      // async reset, active low
  sdcrb_link_if.host       link,            // register and parallel port
  input  wire logic        cmd_valid_in,    // access request
  output logic             cmd_ready_out,   // fifo has room
  input  wire logic        cmd_write_in,    // 1 write, 0 read
  input  wire logic [4:0]  cmd_addr_in,     // word address
  input  wire logic [3:0]  cmd_be_in,       // byte enables
  input  wire logic [31:0] cmd_data_in,     // write data
  output logic             resp_valid_out,  // read answer pulse
  output logic [31:0]      resp_data_out,   // read answer data
  input  wire logic        update_req_in,   // transfer strobe request
  input  wire logic        master_reset_in, // defaults restore request
  input  wire logic [2:0]  profile_sel_in,  // profile to present
  input  wire logic [3:0]  func_sel_in,     // function to present
  input  wire logic [31:0] par_data_in      // parallel data to present
);

  typedef struct packed {
    sdcrb_pkg::sdcrb_host_state_e state;
    logic                         wr_en;
    logic                         rd_en;
    logic [4:0]                   addr;
    logic [3:0]                   be;
    logic [31:0]                  wdata;
    logic                         io_update;
    logic                         master_reset;
    logic [2:0]                   profile_sel;
    logic [3:0]                   func_sel;
    logic [31:0]                  par_data;
    logic                         resp_valid;
    logic [31:0]                  resp_data;
    logic                         cmd_ready;
    logic [4:0]                   fill;
  } sdcrb_host_s;

  sdcrb_host_s           r;
  sdcrb_host_s           next_r;
  sdcrb_pkg::sdcrb_cmd_s push_cmd;
  sdcrb_pkg::sdcrb_cmd_s head_cmd;
  sdcrb_pkg::sdcrb_cmd_t head_bits;
  logic                  head_valid;
  logic                  pop;
  logic                  fifo_ready;

  // =====================================================
  // command buffer; stalls while a read is outstanding
  assign push_cmd = '{write: cmd_write_in, addr: cmd_addr_in, be: cmd_be_in,
                      data: cmd_data_in};
  assign head_cmd = sdcrb_pkg::sdcrb_cmd_s'(head_bits);
  assign pop      = head_valid && (r.state == sdcrb_pkg::SDCRB_HOST_IDLE);

  sdcrb_fifo #(
    .WIDTH ($bits(sdcrb_pkg::sdcrb_cmd_s)),
    .DEPTH (`SDCRB_FIFO_DEPTH)
  ) u_cmd_fifo (
    .sys_clk_in    (sys_clk_in),
    .reset_n_in    (reset_n_in),
    .in_valid_in   (cmd_valid_in),
    .in_ready_out  (fifo_ready),
    .in_data_in    (push_cmd),
    .out_valid_out (head_valid),
    .out_ready_in  (pop),
    .out_data_out  (head_bits)
  );

  // =====================================================
  // next state; pins re-timed so they change on the clock edge
  always_comb begin
    next_r              = r;
    next_r.wr_en        = 1'b0;
    next_r.rd_en        = 1'b0;
    next_r.resp_valid   = 1'b0;
    next_r.io_update    = update_req_in;
    next_r.master_reset = master_reset_in;
    next_r.profile_sel  = profile_sel_in;
    next_r.func_sel     = func_sel_in;
    next_r.par_data     = par_data_in;
    // shadow fill count so the room flag leaves a flop yet is late only in the first cycle after reset
    next_r.fill         = r.fill + 5'(cmd_valid_in && fifo_ready) - 5'(pop);
    next_r.cmd_ready    = (next_r.fill != 5'(`SDCRB_FIFO_DEPTH));
    case (r.state)
      sdcrb_pkg::SDCRB_HOST_IDLE: begin
        if (pop) begin
          next_r.wr_en = head_cmd.write;
          next_r.rd_en = !head_cmd.write;
          next_r.addr  = head_cmd.addr;
          next_r.be    = head_cmd.be;
          next_r.wdata = head_cmd.data;
          if (!head_cmd.write) begin
            next_r.state = sdcrb_pkg::SDCRB_HOST_WAIT_RD;
          end
        end
      end
      sdcrb_pkg::SDCRB_HOST_WAIT_RD: begin
        if (link.rvalid) begin
          next_r.resp_valid = 1'b1;
          next_r.resp_data  = link.rdata;
          next_r.state      = sdcrb_pkg::SDCRB_HOST_IDLE;
        end
      end
      default: begin
        next_r.state = sdcrb_pkg::SDCRB_HOST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // =====================================================
  // outputs
  assign link.wr_en        = r.wr_en;
  assign link.rd_en        = r.rd_en;
  assign link.addr         = r.addr;
  assign link.be           = r.be;
  assign link.wdata        = r.wdata;
  assign link.io_update    = r.io_update;
  assign link.master_reset = r.master_reset;
  assign link.profile_sel  = r.profile_sel;
  assign link.func_sel     = r.func_sel;
  assign link.par_data     = r.par_data;
  assign cmd_ready_out     = r.cmd_ready;
  assign resp_valid_out    = r.resp_valid;
  assign resp_data_out     = r.resp_data;

endmodule : sdcrb_host

// ---- dv/sdcrb_link_checker.sv ----
`timescale 1ns/1ns
`include "sdcrb_params.svh"
module sdcrb_link_checker (
  input wire logic                     sys_clk_in,   // clock
  input wire logic                     reset_n_in,   // async reset, active low
  input wire logic                     master_reset, // defaults restore
  input wire logic                     wr_en,        // write strobe
  input wire logic                     rd_en,        // read strobe
  input wire logic [`SDCRB_ADDR_W-1:0] addr,         // word address
  input wire logic [`SDCRB_DATA_W-1:0] rdata,        // read data
  input wire logic                     rvalid        // read data valid
);
  // =====================================================
  // link protocol
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);

  a_read_answered: assert property (rd_en |=> rvalid)
    else $error("read strobe without answer next cycle");
  a_answer_has_cause: assert property (rvalid |-> $past(rd_en))
    else $error("read answer without a read");
  // host holds off read and write strobes while a read waits; io_update is not held off
  a_read_alone: assert property (rd_en |=> !rd_en && !wr_en)
    else $error("strobe right after a read");
  a_unmapped_zero: assert property (rd_en && ((addr > 5'h00 && addr < 5'h1a)
    || addr > `SDCRB_LAST_ADDR) |=> rdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  // =====================================================
  // field contents
  a_ctrl_open_zero: assert property (rd_en && addr == 5'h00 |=>
    (rdata & 32'hfefc_ffff) == 32'h0000_0000)
    else $error("open control bits not zero");
  a_prof_nibble_zero: assert property (rd_en && addr == 5'h1a |=> rdata[31:28] == 4'h0)
    else $error("unused profile nibble not zero");
  a_user_open_zero: assert property (rd_en && addr == 5'h1b |=> rdata[31:25] == 7'h00)
    else $error("open user bits not zero");
  // a read taken the cycle after master reset must see defaults
  a_reset_defaults: assert property (master_reset ##1 (rd_en && addr == 5'h1b) |=>
    rdata == 32'h0000_0800)
    else $error("user register not default after master reset");
endmodule : sdcrb_link_checker

// ---- dv/synth_config_register_bank_test.sv ----
`timescale 1ns/1ns
`include "sdcrb_params.svh"
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin miscompares++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module synth_config_register_bank_test;
  logic        sys_clk_in = 1'b0;
  logic        reset_n_in = 1'b0;
  logic        cmd_valid = 1'b0, cmd_write = 1'b0, update_req = 1'b0, mreset = 1'b0;
  logic [4:0]  cmd_addr = 5'h00;
  logic [3:0]  cmd_be = 4'h0, func = 4'h0;
  logic [2:0]  prof = 3'h0;
  logic [31:0] cmd_data = 32'h0, pdata = 32'h0, resp_data, frequency_tuning_word;
  logic [15:0] phase_offset_word;
  logic [11:0] amplitude_word;
  logic        cmd_ready, resp_valid, sine, stream, busy, locked;
  int          miscompares = 0, checked = 0;
  sdcrb_link_if link ();

  // 125 mhz clock
  always #4 sys_clk_in = ~sys_clk_in;

  // =====================================================
  // both ends joined by the link
  sdcrb_host u_sdcrb_host (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .link(link.host),
    .cmd_valid_in(cmd_valid), .cmd_ready_out(cmd_ready), .cmd_write_in(cmd_write),
    .cmd_addr_in(cmd_addr), .cmd_be_in(cmd_be), .cmd_data_in(cmd_data),
    .resp_valid_out(resp_valid), .resp_data_out(resp_data), .update_req_in(update_req),
    .master_reset_in(mreset), .profile_sel_in(prof), .func_sel_in(func), .par_data_in(pdata));
  sdcrb_device u_sdcrb_device (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
    .link(link.device), .ftw_out(frequency_tuning_word), .pow_out(phase_offset_word), .amp_out(amplitude_word), .sine_select_out(sine),
    .stream_mode_out(stream), .pll_cal_busy_out(busy), .pll_locked_out(locked));
  sdcrb_link_checker u_sdcrb_link_checker (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
    .master_reset(link.master_reset), .wr_en(link.wr_en), .rd_en(link.rd_en),
    .addr(link.addr), .rdata(link.rdata), .rvalid(link.rvalid));

  // =====================================================
  // drivers
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk_in);
  endtask : cyc

  // ready is looked at mid-cycle so the accepting edge is never raced
  task automatic push(input logic w, input logic [4:0] a, input logic [3:0] b,
                      input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk_in);
    cmd_valid <= 1'b1;
    {cmd_write, cmd_addr, cmd_be, cmd_data} <= {w, a, b, d};
    do @(negedge sys_clk_in); while (cmd_ready !== 1'b1 && ++n < 40);
    @(posedge sys_clk_in);
    cmd_valid <= 1'b0;
  endtask : push

  task automatic rd(input logic [4:0] a, input logic [31:0] exp);
    int n;
    n = 0;
    push(1'b0, a, 4'hf, 32'h0000_0000);
    do @(negedge sys_clk_in); while (resp_valid !== 1'b1 && ++n < 20);
    `CHK(resp_valid, 1'b1)
    `CHK(resp_data, exp)
  endtask : rd

  // lets a queued write land before the strobe
  task automatic upd();
    cyc(4);
    @(posedge sys_clk_in);
    update_req <= 1'b1;
    @(posedge sys_clk_in);
    update_req <= 1'b0;
    cyc(3);
  endtask : upd

  task automatic par(input logic [3:0] f, input logic [31:0] d);
    @(posedge sys_clk_in);
    {func, pdata} <= {f, d};
    cyc(3);
  endtask : par

  // =====================================================
  // scenarios
  task automatic t_defaults();
    `CHK({sine, stream, busy, locked}, 4'b1000)
    `CHK(cmd_ready, 1'b1)
    rd(5'h00, 32'h0001_0000);
    rd(5'h1b, 32'h0000_0800);
    rd(5'h05, 32'h0000_0000);
    rd(5'h1c, 32'h0000_0000);
  endtask : t_defaults

  task automatic t_masks();
    push(1'b1, 5'h1a, 4'hf, 32'hffff_ffff);
    rd(5'h1a, 32'h0fff_ffff);
    push(1'b1, 5'h1a, 4'h1, 32'h5555_5512);
    rd(5'h1a, 32'h0fff_ff12);
    push(1'b1, 5'h1b, 4'hf, 32'hffff_ffff);
    rd(5'h1b, 32'h00ff_ffff);
    push(1'b1, 5'h1b, 4'hf, 32'h0000_0800);
    push(1'b1, 5'h1c, 4'hf, 32'hffff_ffff);
    rd(5'h1c, 32'h0000_0000);
    push(1'b1, 5'h00, 4'hf, 32'hfefd_ffff);
    rd(5'h00, 32'h0001_0000);
  endtask : t_masks

  task automatic t_transfer();
    push(1'b1, 5'h00, 4'hf, 32'h0000_0000);
    cyc(6);
    `CHK(sine, 1'b1)
    upd();
    `CHK(sine, 1'b0)
    push(1'b1, 5'h1a, 4'hf, 32'h0abc_1234);
    cyc(6);
    `CHK(phase_offset_word, 16'h0000)
    @(posedge sys_clk_in);
    prof <= 3'h7;
    cyc(3);
    `CHK({phase_offset_word, amplitude_word}, {16'h1234, 12'habc})
    push(1'b1, 5'h00, 4'hf, 32'h0001_0000);
    upd();
    `CHK(sine, 1'b1)
  endtask : t_transfer

  task automatic t_parallel();
    @(posedge sys_clk_in);
    prof <= 3'h0;
    cyc(3);
    par(4'h0, 32'hdead_beef);
    cyc(4);
    `CHK(frequency_tuning_word, 32'h0000_0000)
    upd();
    `CHK(frequency_tuning_word, 32'hdead_beef)
    push(1'b1, 5'h00, 4'hf, 32'h0003_0000);
    upd();
    `CHK(stream, 1'b1)
    par(4'h0, 32'h1111_2222);
    par(4'h1, 32'h3333_4444);
    par(4'h2, 32'h5555_6abc);
    par(4'h3, 32'h7777_8888);
    `CHK({frequency_tuning_word, phase_offset_word, amplitude_word}, {32'h1111_2222, 16'h4444, 12'habc})
  endtask : t_parallel

  task automatic t_pll();
    int n;
    n = 0;
    push(1'b1, 5'h00, 4'hf, 32'h0101_0000);
    cyc(6);
    `CHK({busy, locked}, 2'b10)
    do @(negedge sys_clk_in); while (locked !== 1'b1 && ++n < 400);
    `CHK(n > 240 && n < 256, 1'b1)
    rd(5'h1b, 32'h0100_0800);
    push(1'b1, 5'h00, 4'hf, 32'h0101_0000);
    cyc(8);
    `CHK(busy, 1'b0)
    push(1'b1, 5'h00, 4'hf, 32'h0001_0000);
    push(1'b1, 5'h00, 4'hf, 32'h0101_0000);
    cyc(8);
    `CHK(busy, 1'b1)
  endtask : t_pll

  task automatic t_mreset();
    push(1'b1, 5'h00, 4'hf, 32'h0000_0000);
    upd();
    @(posedge sys_clk_in);
    mreset <= 1'b1;
    rd(5'h1b, 32'h0000_0800);
    @(posedge sys_clk_in);
    mreset <= 1'b0;
    cyc(3);
    `CHK({sine, busy, locked}, 3'b100)
    rd(5'h00, 32'h0001_0000);
  endtask : t_mreset

  task automatic tally_and_finish();
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish

  // main sequence
  initial begin
    repeat (8) @(posedge sys_clk_in);
    reset_n_in <= 1'b1;
    cyc(3);
    t_defaults();
    t_masks();
    t_transfer();
    t_parallel();
    t_pll();
    t_mreset();
    tally_and_finish();
  end

  // the whole run needs under a thousand cycles, calibration included
  initial begin
    repeat (5000) @(posedge sys_clk_in);
    miscompares++;
    tally_and_finish();
  end
endmodule : synth_config_register_bank_test
